// ===== hdl/lae_pkg.sv
package lae_pkg;
  localparam int LAE_INSN_W = 14;
  localparam int LAE_DATA_W = 8;
  localparam int LAE_ADDR_W = 7;
  // encodings of the literal and file operations handled here
  localparam logic [4:0] LAE_ADD_IMM_TOP = 5'h1f;   // 11 111x
  localparam logic [5:0] LAE_AND_IMM_TOP = 6'h39;   // 11 1001
  localparam logic [5:0] LAE_AND_FILE_TOP = 6'h05;  // 00 0101
  localparam logic [5:0] LAE_FILE_MOVE_TOP = 6'h08; // 00 1000
  localparam logic [5:0] LAE_ADD_FILE_TOP = 6'h07;  // 00 0111
  localparam int LAE_DEST_BIT = 7;
  localparam logic [LAE_ADDR_W-1:0] LAE_TIMER_ZERO_ADDR = 7'h01;
  localparam logic [7:0] LAE_W_RESET = 8'h00;
  localparam logic [2:0] LAE_FLAGS_RESET = 3'h0;
  localparam int LAE_OSC_PER_CYCLE = 4;
  localparam logic [1:0] LAE_PHASE_LAST = 2'h3;

  typedef enum logic [1:0] {
    LAE_FETCH = 2'b00,
    LAE_EXEC = 2'b01,
    LAE_IDLE = 2'b11
  } lae_state_e;

  typedef struct packed {
    logic carry;
    logic nibble_overflow_flag;
    logic zero;
  } lae_flags_s;

  typedef struct packed {
    logic we;
    logic [LAE_ADDR_W-1:0] addr;
    logic [LAE_DATA_W-1:0] data;
  } lae_file_wr_s;
endpackage

// ===== hdl/lae_literal_alu_execute.sv
// Operation
// - read-modify-write of I/O uses pin levels
// - timer-zero count write clears its prescaler when prescaler_to_timer is set
// - branch or true test adds idle cycle
// - add_immediate_op adds literal, sets carry, nibble, zero
// - add_immediate_op writes only the accumulator
// - and_immediate_op ANDs literal, sets only Z
// - and_immediate_op result goes to accumulator
// - instruction cycle spans four oscillator periods
// - destination select zero accumulator, one file
`timescale 1ns/1ps
module lae_literal_alu_execute
  import lae_pkg::*;
#(
  parameter int OSC_PER_CYCLE = LAE_OSC_PER_CYCLE
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic insn_valid,
  input wire logic [LAE_INSN_W-1:0] insn,
  input wire logic pc_change,
  input wire logic cond_true,
  input wire logic [LAE_DATA_W-1:0] file_rdata,
  input wire logic file_is_io,
  input wire logic [LAE_DATA_W-1:0] io_pins,
  input wire logic prescaler_to_timer,
  output logic [LAE_DATA_W-1:0] w_ff,
  output lae_flags_s flags_ff,
  output lae_file_wr_s file_wr_ff,
  output logic prescaler_clr_ff,
  output logic insn_done_ff,
  output logic idle_cycle_ff
);
  // the phase counter is two bits wide, so only four periods per cycle fit
  if (OSC_PER_CYCLE != LAE_OSC_PER_CYCLE)
  begin : g_osc_check
    $error("oscillator periods per instruction cycle must be 4");
  end

  logic [1:0] phase_ff;
  logic [LAE_DATA_W-1:0] pins_s1_ff;
  logic [LAE_DATA_W-1:0] pins_s2_ff;
  lae_state_e state_ff;
  logic cycle_end;
  logic [5:0] top6;
  logic is_add_imm;
  logic is_and_imm;
  logic is_and_file;
  logic is_move_file;
  logic is_add_file;
  logic dest_file;
  logic [LAE_DATA_W-1:0] src_f;
  logic [LAE_DATA_W-1:0] result;
  lae_flags_s nxt_flags;
  logic writes_file;

  function automatic logic [LAE_DATA_W+1:0] add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    add_flags = {s[8], n[4], s[7:0]};
  endfunction

  // four oscillator periods per instruction cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      phase_ff <= 2'h0;
    else if (clk_en)
      phase_ff <= phase_ff + 2'h1;
  end
  assign cycle_end = clk_en && (phase_ff == LAE_PHASE_LAST);

  // pins come from outside, so two stages before use
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pins_s1_ff <= 8'h00;
      pins_s2_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      pins_s1_ff <= io_pins;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  assign top6 = insn[13:8];
  assign is_add_imm = insn_valid && (top6[5:1] == LAE_ADD_IMM_TOP);
  assign is_and_imm = insn_valid && (top6 == LAE_AND_IMM_TOP);
  assign is_and_file = insn_valid && (top6 == LAE_AND_FILE_TOP);
  assign is_move_file = insn_valid && (top6 == LAE_FILE_MOVE_TOP);
  assign is_add_file = insn_valid && (top6 == LAE_ADD_FILE_TOP);
  assign dest_file = insn[LAE_DEST_BIT];
  assign src_f = file_is_io ? pins_s2_ff : file_rdata;
  assign writes_file = (is_and_file || is_move_file || is_add_file) && dest_file;

  always_comb
  begin
    logic [9:0] a;
    a = 10'h000;
    result = w_ff;
    nxt_flags = flags_ff;
    if (is_add_imm)
    begin
      a = add_flags(w_ff, insn[7:0]);
      result = a[7:0];
      nxt_flags = '{carry: a[9], nibble_overflow_flag: a[8], zero: (a[7:0] == 8'h00)};
    end
    else if (is_and_imm)
    begin
      result = w_ff & insn[7:0];
      nxt_flags.zero = (result == 8'h00);
    end
    else if (is_add_file)
    begin
      a = add_flags(w_ff, src_f);
      result = a[7:0];
      nxt_flags = '{carry: a[9], nibble_overflow_flag: a[8], zero: (a[7:0] == 8'h00)};
    end
    else if (is_and_file)
    begin
      result = w_ff & src_f;
      nxt_flags.zero = (result == 8'h00);
    end
    else if (is_move_file)
    begin
      result = src_f;
      nxt_flags.zero = (result == 8'h00);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_ff <= LAE_FETCH;
    else if (cycle_end)
      case (state_ff)
        // every executing cycle may branch, whichever state it ran in
        LAE_FETCH, LAE_EXEC:
          if (!insn_valid)
            state_ff <= LAE_FETCH;
          else if (pc_change || cond_true)
            state_ff <= LAE_IDLE;
          else
            state_ff <= LAE_EXEC;
        // leaving idle for exec keeps the exit a one-bit change
        LAE_IDLE: state_ff <= LAE_EXEC;
        default: state_ff <= LAE_FETCH;
      endcase
  end

  // a single accumulator write per cycle; file ops with d=1 leave it alone
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      w_ff <= LAE_W_RESET;
      flags_ff <= LAE_FLAGS_RESET;
    end
    else if (cycle_end && state_ff != LAE_IDLE)
    begin
      if (is_add_imm || is_and_imm)
        w_ff <= result;
      else if ((is_and_file || is_move_file || is_add_file) && !dest_file)
        w_ff <= result;
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      file_wr_ff <= '0;
      prescaler_clr_ff <= 1'b0;
      insn_done_ff <= 1'b0;
      idle_cycle_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      file_wr_ff.we <= cycle_end && state_ff != LAE_IDLE && writes_file;
      file_wr_ff.addr <= insn[LAE_ADDR_W-1:0];
      file_wr_ff.data <= result;
      // prescaler is shared, so only clear it while the timer owns it
      prescaler_clr_ff <= cycle_end && state_ff != LAE_IDLE && writes_file
        && insn[LAE_ADDR_W-1:0] == LAE_TIMER_ZERO_ADDR && prescaler_to_timer;
      insn_done_ff <= cycle_end && state_ff != LAE_IDLE && insn_valid;
      idle_cycle_ff <= cycle_end && state_ff != LAE_IDLE && insn_valid
        && (pc_change || cond_true);
    end
  end

  property p_add_imm;
    @(posedge clk) disable iff (reset)
    (cycle_end && state_ff != LAE_IDLE && is_add_imm)
      |=> (w_ff == 8'($past(w_ff) + $past(insn[7:0]))) && !file_wr_ff.we;
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

  property p_and_imm;
    @(posedge clk) disable iff (reset)
    (cycle_end && state_ff != LAE_IDLE && is_and_imm)
      |=> w_ff == ($past(w_ff) & $past(insn[7:0])) && flags_ff.carry == $past(flags_ff.carry);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

  sequence s_branch;
    cycle_end && state_ff != LAE_IDLE && insn_valid && (pc_change || cond_true);
  endsequence
  property p_idle;
    @(posedge clk) disable iff (reset)
    s_branch |=> state_ff == LAE_IDLE && idle_cycle_ff;
  endproperty
  a_idle: assert property (p_idle) else $error("missing idle cycle");

  sequence s_idle_slot;
    cycle_end && state_ff == LAE_IDLE;
  endsequence
  property p_idle_slot;
    @(posedge clk) disable iff (reset)
    s_idle_slot |=> !insn_done_ff && !file_wr_ff.we && w_ff == $past(w_ff);
  endproperty
  a_idle_slot: assert property (p_idle_slot) else $error("idle cycle had an effect");

  sequence s_file_write;
    cycle_end && state_ff != LAE_IDLE && writes_file;
  endsequence
  property p_file_dest;
    @(posedge clk) disable iff (reset)
    s_file_write |=> file_wr_ff.we && w_ff == $past(w_ff);
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("file destination wrong");

  sequence s_io_move;
    cycle_end && state_ff != LAE_IDLE && is_move_file && file_is_io;
  endsequence
  property p_io_source;
    @(posedge clk) disable iff (reset)
    s_io_move |=> file_wr_ff.data == $past(pins_s2_ff);
  endproperty
  a_io_source: assert property (p_io_source) else $error("io source not pins");

  property p_hold;
    @(posedge clk) disable iff (reset)
    !clk_en |=> $stable(phase_ff) && $stable(w_ff) && $stable(state_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while disabled");

  property p_prescale;
    @(posedge clk) disable iff (reset)
    prescaler_clr_ff |-> file_wr_ff.we && file_wr_ff.addr == LAE_TIMER_ZERO_ADDR;
  endproperty
  a_prescale: assert property (p_prescale) else $error("stray prescaler clear");
endmodule

// ===== tb/lae_testbench.sv
`timescale 1ns/1ps
module testbench;
  import lae_pkg::*;
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s exp %h got %h", n, e, g); end end
  logic clk = 0, reset = 1, clk_en = 1, insn_valid = 0, pc_change = 0, cond_true = 0;
  logic file_is_io = 0, prescaler_to_timer = 0, prescaler_clr_ff, insn_done_ff, idle_cycle_ff;
  logic [13:0] insn = '0;
  logic [7:0] file_rdata = '0, io_pins = '0, w_ff, wm = '0;
  lae_flags_s flags_ff, fm = '0;
  lae_file_wr_s file_wr_ff, wr_last = '0, ewr = '0;
  int bad_count = 0, checks = 0, cycles = 0, wr_cnt = 0, clr_cnt = 0, idle_cnt = 0;
  int nwr = 0, nclr = 0, nidle = 0, gap_on = 0, pend = 0;
  lae_literal_alu_execute i_dut (.clk(clk), .reset(reset), .clk_en(clk_en),
    .insn_valid(insn_valid), .insn(insn), .pc_change(pc_change), .cond_true(cond_true),
    .file_rdata(file_rdata), .file_is_io(file_is_io), .io_pins(io_pins),
    .prescaler_to_timer(prescaler_to_timer), .w_ff(w_ff), .flags_ff(flags_ff),
    .file_wr_ff(file_wr_ff), .prescaler_clr_ff(prescaler_clr_ff),
    .insn_done_ff(insn_done_ff), .idle_cycle_ff(idle_cycle_ff));
  always #25 clk = ~clk;
  // pulses are counted on the falling edge so the counts never race the drivers
  always @(negedge clk)
  begin
    if (file_wr_ff.we) wr_last <= file_wr_ff;
    wr_cnt <= wr_cnt + file_wr_ff.we;
    clr_cnt <= clr_cnt + prescaler_clr_ff;
    idle_cnt <= idle_cnt + idle_cycle_ff;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic run(input logic [13:0] op, input logic pcc, ct, io, pre, input logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    insn <= op;
    pc_change <= pcc;
    cond_true <= ct;
    file_is_io <= io;
    prescaler_to_timer <= pre;
    file_rdata <= rd;
    do
    begin
      @(negedge clk);
      n++;
    end while (insn_done_ff !== 1'b1 && n < 20);
    #1;
    `CHK("w", wm, w_ff)
    `CHK("flags", fm, flags_ff)
    `CHK("writes", nwr, wr_cnt)
    `CHK("last write", ewr, wr_last)
    `CHK("clears", nclr, clr_cnt)
    `CHK("idles", nidle, idle_cnt)
    if (gap_on) `CHK("gap", (pend ? 8 : 4), n)
    gap_on = 1;
    pend = pcc | ct;
  endtask
  task automatic t_add(input logic [7:0] k, input logic x);
    logic [8:0] s;
    s = wm + k;
    fm = {s[8], (wm[3:0] + k[3:0]) > 5'h0f, s[7:0] == 8'h00};
    wm = s[7:0];
    run({LAE_ADD_IMM_TOP, x, k}, 0, 0, 0, 0, 8'h00);
  endtask
  task automatic t_and(input logic [7:0] k, input logic pcc, ct);
    wm = wm & k;
    fm.zero = wm == 8'h00;
    nidle += pcc | ct;
    run({LAE_AND_IMM_TOP, k}, pcc, ct, 0, 0, 8'h00);
  endtask
  task automatic t_file(input logic [6:0] a, input logic d, io, pre, input logic [7:0] rd);
    logic [7:0] v;
    v = io ? io_pins : rd;
    fm.zero = v == 8'h00;
    if (d)
    begin
      nwr++;
      ewr = {1'b1, a, v};
      nclr += (a == LAE_TIMER_ZERO_ADDR) & pre;
    end
    else
      wm = v;
    run({LAE_FILE_MOVE_TOP, d, a}, 0, 0, io, pre, rd);
  endtask
  task automatic t_falu(input logic [5:0] op, input logic [6:0] a, input logic d,
    input logic [7:0] rd);
    logic [8:0] s;
    logic [7:0] v;
    s = wm + rd;
    v = (op == LAE_ADD_FILE_TOP) ? s[7:0] : (wm & rd);
    if (op == LAE_ADD_FILE_TOP)
      fm = {s[8], (wm[3:0] + rd[3:0]) > 5'h0f, v == 8'h00};
    else
      fm.zero = v == 8'h00;
    if (d)
    begin
      nwr++;
      ewr = {1'b1, a, v};
      nclr += (a == LAE_TIMER_ZERO_ADDR);
    end
    else
      wm = v;
    run({op, d, a}, 0, 0, 0, 1, rd);
  endtask
  task automatic sc_hold();
    @(posedge clk);
    clk_en <= 1'b0;
    insn <= {LAE_ADD_IMM_TOP, 1'b0, 8'h11};
    repeat (6) @(negedge clk);
    `CHK("held w", wm, w_ff)
    `CHK("held done", 1'b0, insn_done_ff)
    @(posedge clk);
    clk_en <= 1'b1;
    // the frozen phases shorten this one wait, so its gap is not judged
    gap_on = 0;
    t_add(8'h11, 0);
    $display("clock enable test done");
  endtask
  task automatic sc_reset();
    @(posedge clk);
    reset <= 1'b1;
    insn <= '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    wm = '0;
    fm = '0;
    gap_on = 0;
    `CHK("reset w", wm, w_ff)
    `CHK("reset flags", fm, flags_ff)
    `CHK("reset write", 16'h0000, file_wr_ff)
    `CHK("reset done", 1'b0, insn_done_ff)
    $display("reset test done");
  endtask
  task automatic sc_falu();
    t_add(8'h3c, 0);
    t_falu(LAE_ADD_FILE_TOP, 7'h21, 1'b0, 8'hc4);
    t_falu(LAE_AND_FILE_TOP, LAE_TIMER_ZERO_ADDR, 1'b1, 8'hff);
    t_falu(LAE_ADD_FILE_TOP, 7'h22, 1'b1, 8'h17);
    t_add(8'h00, 0);
    $display("file alu tests done");
  endtask
  task automatic sc_add();
    t_add(8'h10, 0);
    t_add(8'h15, 1);
    t_add(8'hdb, 0);
    $display("add tests done");
  endtask
  task automatic sc_and();
    t_and(8'h5f, 0, 0);
    t_add(8'ha3, 0);
    t_and(8'h5f, 1, 0);
    t_and(8'h00, 0, 1);
    t_add(8'h01, 0);
    $display("and and idle tests done");
  endtask
  task automatic sc_file();
    t_file(LAE_TIMER_ZERO_ADDR, 1, 0, 1, 8'h00);
    t_file(LAE_TIMER_ZERO_ADDR, 1, 0, 0, 8'h80);
    t_file(7'h06, 1, 1, 0, 8'ha5);
    t_file(7'h20, 0, 0, 0, 8'h3c);
    $display("file tests done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 0;
    insn_valid <= 1;
    // pins settle well before the first read through the synchroniser
    io_pins <= 8'h5a;
    sc_add();
    sc_and();
    sc_file();
    sc_hold();
    sc_reset();
    sc_falu();
    print_verdict();
  end
endmodule
